//--- logic/acs_pkg.sv
// constants shared by the conversion sequencer
// assumes a 16-bit register port with word offsets
package acs_pkg;
  localparam int unsigned RES_W = 10;
  localparam int unsigned DAT_W = 16;
  localparam int unsigned ADR_W = 4;
  // register offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_RESH = 4'h1;
  localparam logic [3:0] OFF_RESL = 4'h2;
  localparam logic [3:0] OFF_PREV = 4'h3;
  localparam logic [3:0] OFF_ACC  = 4'h4;
  localparam logic [3:0] OFF_SETP = 4'h5;
  localparam logic [3:0] OFF_ERR  = 4'h6;
  localparam logic [3:0] OFF_THR  = 4'h7;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'h9;
  localparam logic [3:0] OFF_STPE = 4'ha;
  // control bit positions
  localparam int unsigned CTL_EN   = 0;
  localparam int unsigned CTL_GO   = 1;
  localparam int unsigned CTL_CONT = 2;
  localparam int unsigned CTL_PSIS = 3;
  localparam int unsigned CTL_DSEN = 4;
  localparam int unsigned CTL_TSEL = 5;
  // status and mask bit positions
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_THR  = 1;
  localparam int unsigned ST_MATH = 2;
  localparam int unsigned ST_W    = 3;
  // values after reset and at conversion start
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [9:0]  RST_CODE  = 10'h000;
  localparam logic [9:0]  TRIAL_MSB = 10'h200;
  localparam logic [3:0]  MSB_IDX   = 4'h9;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CALC} acs_state_e;
endpackage

//--- logic/acs_sequencer.sv
// successive-approximation conversion sequencer with register port
// assumes synchronous inputs and a comparator answer valid each cycle
// Behaviour
// - conversions run only while the enable bit is one
// - go bit write or external trigger starts a conversion
// - continuous mode restarts a conversion after each one ends
// - at the end old result moves to previous when select is set
// - completion clears go unless continuous mode or a trigger in the same cycle keeps it set
// - completion sets done and computation flags, updates accumulator
// - error computed every conversion, or every second with double sample
// - threshold flag set when the error meets the threshold condition
// - stage error computed on same cadence and may drive the compare
// - filter and threshold work runs after the conversion ends
// - clearing go aborts and stores the partial sample in result bytes
// - unresolved bits of an aborted sample copy the last resolved bit
// - an aborted sample still goes through filter and threshold work
// - reset restores all registers, disables and cancels conversion
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module acs_sequencer (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic [3:0]           regAddr,
  input  wire logic [15:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [15:0]          regRdData,
  input  wire logic                 extTrig,
  input  wire logic                 cmpIn,
  output logic      [9:0]           dacCode,
  output logic                      sampling,
  output logic                      irq
);
  acs_pkg::acs_state_e state_r;
  logic                enable_r, go_r, cont_r, psis_r, dsen_r, tsel_r;
  logic [3:0]          bitIdx_r;
  logic [9:0]          code_r, res_r, prev_r;
  logic [15:0]         acc_r, setp_r, thr_r, err_r, stpe_r;
  logic [2:0]          stat_r, mask_r;
  logic                parity_r;
  logic [15:0]         rd_r;
  logic                irq_r;
  logic                wrCtrl, wrStat, finish, calcDue, thrHit;
  logic [9:0]          newCode, partial, finalCode;
  logic [2:0]          statSet;
  logic [15:0]         errNxt, stpeNxt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  assign wrCtrl = regWr && regAddr == acs_pkg::OFF_CTRL;
  assign wrStat = regWr && regAddr == acs_pkg::OFF_STAT;

  // resolve the trial bit and arm the next one
  always_comb begin
    newCode = code_r;
    newCode[bitIdx_r] = cmpIn;
    if (bitIdx_r != 4'h0) begin
      newCode[bitIdx_r - 4'h1] = 1'b1;
    end
  end

  // fill unresolved bits with the last resolved one
  always_comb begin
    partial = acs_pkg::RST_CODE;
    for (int i = 0; i < acs_pkg::RES_W; i++) begin
      if (i > int'(bitIdx_r)) begin
        partial[i] = code_r[i];
      end else if (bitIdx_r != acs_pkg::MSB_IDX) begin
        partial[i] = code_r[bitIdx_r + 4'h1];
      end
    end
  end

  // abort when go drops mid conversion, else normal end
  assign finish    = state_r == acs_pkg::ST_CONV && enable_r &&
                     (!go_r || bitIdx_r == 4'h0);
  assign finalCode = go_r ? newCode : partial;
  assign calcDue   = !dsen_r || !parity_r;
  assign errNxt    = setp_r - {6'h00, res_r};
  assign stpeNxt   = {6'h00, res_r} - {6'h00, prev_r};
  assign thrHit    = tsel_r ? $signed(stpeNxt) > $signed(thr_r)
                            : $signed(errNxt) > $signed(thr_r);

  // control bits
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r <= 1'b0;
      cont_r   <= 1'b0;
      psis_r   <= 1'b0;
      dsen_r   <= 1'b0;
      tsel_r   <= 1'b0;
    end else if (wrCtrl) begin
      enable_r <= regWrData[acs_pkg::CTL_EN];
      cont_r   <= regWrData[acs_pkg::CTL_CONT];
      psis_r   <= regWrData[acs_pkg::CTL_PSIS];
      dsen_r   <= regWrData[acs_pkg::CTL_DSEN];
      tsel_r   <= regWrData[acs_pkg::CTL_TSEL];
    end
  end

  // go bit: software, trigger, completion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      go_r <= 1'b0;
    end else if (wrCtrl) begin
      go_r <= regWrData[acs_pkg::CTL_EN] &&
              (regWrData[acs_pkg::CTL_GO] || extTrig);
    end else if (!enable_r) begin
      go_r <= 1'b0;
    end else if (finish && !cont_r) begin
      go_r <= extTrig;
    end else begin
      go_r <= go_r || extTrig;
    end
  end

  // sequencing and successive approximation
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r  <= acs_pkg::ST_IDLE;
      bitIdx_r <= acs_pkg::MSB_IDX;
      code_r   <= acs_pkg::RST_CODE;
    end else begin
      unique case (state_r)
        acs_pkg::ST_IDLE: begin
          if (enable_r && go_r) begin
            state_r  <= acs_pkg::ST_CONV;
            bitIdx_r <= acs_pkg::MSB_IDX;
            code_r   <= acs_pkg::TRIAL_MSB;
          end
        end
        acs_pkg::ST_CONV: begin
          if (!enable_r) begin
            state_r <= acs_pkg::ST_IDLE;
          end else if (finish) begin
            state_r <= acs_pkg::ST_CALC;
            code_r  <= finalCode;
          end else begin
            code_r   <= newCode;
            bitIdx_r <= bitIdx_r - 4'h1;
          end
        end
        acs_pkg::ST_CALC: begin
          state_r <= acs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // results, accumulator and sample parity
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      res_r    <= acs_pkg::RST_CODE;
      prev_r   <= acs_pkg::RST_CODE;
      acc_r    <= acs_pkg::RST_WORD;
      parity_r <= 1'b0;
    end else if (finish) begin
      if (psis_r) begin
        prev_r <= res_r;
      end
      res_r    <= finalCode;
      acc_r    <= acc_r + {6'h00, finalCode};
      parity_r <= !parity_r;
    end
  end

  // filter and threshold stage, one cycle after the result
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      err_r  <= acs_pkg::RST_WORD;
      stpe_r <= acs_pkg::RST_WORD;
    end else if (state_r == acs_pkg::ST_CALC && calcDue) begin
      err_r  <= errNxt;
      stpe_r <= stpeNxt;
    end
  end

  // software set points
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      setp_r <= acs_pkg::RST_WORD;
      thr_r  <= acs_pkg::RST_WORD;
      mask_r <= 3'h0;
    end else if (regWr) begin
      if (regAddr == acs_pkg::OFF_SETP) begin
        setp_r <= regWrData;
      end
      if (regAddr == acs_pkg::OFF_THR) begin
        thr_r <= regWrData;
      end
      if (regAddr == acs_pkg::OFF_MASK) begin
        mask_r <= regWrData[acs_pkg::ST_W-1:0];
      end
    end
  end

  // sticky flags, set wins over write-one clear
  always_comb begin
    statSet = 3'h0;
    statSet[acs_pkg::ST_DONE] = finish;
    statSet[acs_pkg::ST_MATH] = finish;
    statSet[acs_pkg::ST_THR]  = state_r == acs_pkg::ST_CALC &&
                                calcDue && thrHit;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= (stat_r & ~(wrStat ? regWrData[2:0] : 3'h0)) |
                statSet;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((stat_r | statSet) & mask_r);
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_r <= acs_pkg::RST_WORD;
    end else if (regRd) begin
      unique case (regAddr)
        acs_pkg::OFF_CTRL: rd_r <= {10'h000, tsel_r, dsen_r, psis_r,
                                    cont_r, go_r, enable_r};
        acs_pkg::OFF_RESH: rd_r <= {14'h0000, res_r[9:8]};
        acs_pkg::OFF_RESL: rd_r <= {8'h00, res_r[7:0]};
        acs_pkg::OFF_PREV: rd_r <= {6'h00, prev_r};
        acs_pkg::OFF_ACC:  rd_r <= acc_r;
        acs_pkg::OFF_SETP: rd_r <= setp_r;
        acs_pkg::OFF_ERR:  rd_r <= err_r;
        acs_pkg::OFF_THR:  rd_r <= thr_r;
        acs_pkg::OFF_STAT: rd_r <= {13'h0000, stat_r};
        acs_pkg::OFF_MASK: rd_r <= {13'h0000, mask_r};
        acs_pkg::OFF_STPE: rd_r <= stpe_r;
        default:           rd_r <= acs_pkg::RST_WORD;
      endcase
    end else begin
      rd_r <= acs_pkg::RST_WORD;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sampling <= 1'b0;
    end else begin
      sampling <= state_r == acs_pkg::ST_CONV && !finish &&
                  enable_r || state_r == acs_pkg::ST_IDLE &&
                  enable_r && go_r;
    end
  end

  assign regRdData = rd_r;
  assign dacCode   = code_r;
  assign irq       = irq_r;

  sequence finishCont;
    finish && cont_r && go_r && !wrCtrl;
  endsequence
  sequence restartSeq;
    state_r == acs_pkg::ST_CALC ##1 state_r == acs_pkg::ST_IDLE ##1
    state_r == acs_pkg::ST_CONV;
  endsequence

  disabled_stop_a: assert property (
    state_r == acs_pkg::ST_CONV && !enable_r |=> state_r == acs_pkg::ST_IDLE)
    else $error("conversion ran while disabled");
  go_start_a: assert property (
    state_r == acs_pkg::ST_IDLE && enable_r && go_r
    |=> state_r == acs_pkg::ST_CONV && code_r == acs_pkg::TRIAL_MSB)
    else $error("go did not start a conversion");
  trig_go_a: assert property (
    extTrig && enable_r && !wrCtrl |=> go_r)
    else $error("trigger lost");
  cont_retrig_a: assert property (
    finishCont ##1 !regWr |-> restartSeq)
    else $error("continuous mode did not restart");
  prev_copy_a: assert property (
    finish && psis_r |=> prev_r == $past(res_r))
    else $error("previous result not kept");
  go_clear_a: assert property (
    finish && !cont_r && !wrCtrl && !extTrig |=> !go_r)
    else $error("go not cleared at completion");
  done_flags_a: assert property (
    finish |=> stat_r[acs_pkg::ST_DONE] && stat_r[acs_pkg::ST_MATH] &&
    acc_r == $past(acc_r) + {6'h00, $past(finalCode)})
    else $error("completion effects missing");
  skip_calc_a: assert property (
    state_r == acs_pkg::ST_CALC && dsen_r && parity_r
    |=> $stable(err_r) && $stable(stpe_r))
    else $error("error computed on odd sample");
  thr_set_a: assert property (
    state_r == acs_pkg::ST_CALC && calcDue && thrHit
    |=> stat_r[acs_pkg::ST_THR] ##1
    (irq_r || !mask_r[acs_pkg::ST_THR] || $changed(mask_r)))
    else $error("threshold flag not set");
  calc_after_a: assert property (
    finish |=> state_r == acs_pkg::ST_CALC ##1 err_r == $past(errNxt) ||
    !$past(calcDue))
    else $error("filter stage out of order");
  abort_fill_a: assert property (
    finish && !go_r |=> res_r == $past(partial))
    else $error("aborted sample wrong");
  flag_hold_a: assert property (
    stat_r[acs_pkg::ST_DONE] && !(wrStat && regWrData[acs_pkg::ST_DONE])
    |=> stat_r[acs_pkg::ST_DONE])
    else $error("done flag dropped by hardware");
endmodule

//--- verification/acs_analog_model.sv
// analog source model: comparator answer for the trial code
// assumes the sequencer samples cmpIn on its rising clock edge
`timescale 1ns/1ns
module acs_analog_model (
  input  wire logic [9:0] dacCode,
  input  wire logic [9:0] level,
  output logic            cmpIn
);
  // input level at or above trial code answers one
  assign cmpIn = (level >= dacCode);
endmodule

//--- verification/testbench.sv
// self-checking bench for the conversion sequencer
// assumes the register map and timings of the sequencer hand-over
`timescale 1ns/1ns
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module testbench;
  logic        clock;
  logic        sys_rst;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdData;
  logic        extTrig;
  logic        cmpIn;
  logic [9:0]  dacCode;
  logic        sampling;
  logic        irq;
  logic [9:0]  level;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  acs_sequencer acs_sequencer_i (.clock(clock), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .extTrig(extTrig),
    .cmpIn(cmpIn), .dacCode(dacCode), .sampling(sampling), .irq(irq));
  acs_analog_model acs_analog_model_i (.dacCode(dacCode), .level(level),
    .cmpIn(cmpIn));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict;
    end
  end

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task rc(input string nm, input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    `CHK(nm, e, regRdData)
  endtask

  task irq_is(input logic e);
    repeat (2) @(posedge clock);
    #1;
    `CHK("irq", e, irq)
  endtask

  // enable first, then go in a separate write
  task conv(input logic [9:0] lv, input logic [15:0] ctl);
    level = lv;
    wr(acs_pkg::OFF_CTRL, ctl & 16'hfffd);
    wr(acs_pkg::OFF_CTRL, ctl);
    repeat (16) @(posedge clock);
  endtask

  task t_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rc("ctrl", acs_pkg::OFF_CTRL, 16'h0000);
    rc("resl", acs_pkg::OFF_RESL, 16'h0000);
    rc("acc", acs_pkg::OFF_ACC, 16'h0000);
    rc("stat", acs_pkg::OFF_STAT, 16'h0000);
    rc("unmapped", 4'hc, 16'h0000);
  endtask

  task t_disabled;
    wr(acs_pkg::OFF_CTRL, 16'h0002);
    repeat (16) @(posedge clock);
    #1;
    `CHK("sampling", 1'b0, sampling)
    rc("stat", acs_pkg::OFF_STAT, 16'h0000);
  endtask

  task t_basic;
    conv(10'h2a5, 16'h000b);
    rc("resh", acs_pkg::OFF_RESH, 16'h0002);
    rc("resl", acs_pkg::OFF_RESL, 16'h00a5);
    rc("prev", acs_pkg::OFF_PREV, 16'h0000);
    rc("acc", acs_pkg::OFF_ACC, 16'h02a5);
    rc("ctrl", acs_pkg::OFF_CTRL, 16'h0009);
    rc("stat", acs_pkg::OFF_STAT, 16'h0005);
    irq_is(1'b0);
    wr(acs_pkg::OFF_MASK, 16'h0001);
    irq_is(1'b1);
    repeat (20) @(posedge clock);
    rc("stat", acs_pkg::OFF_STAT, 16'h0005);
    wr(acs_pkg::OFF_STAT, 16'h0007);
    irq_is(1'b0);
  endtask

  task t_thresh;
    wr(acs_pkg::OFF_SETP, 16'h0300);
    wr(acs_pkg::OFF_THR, 16'h0100);
    wr(acs_pkg::OFF_MASK, 16'h0002);
    conv(10'h155, 16'h000b);
    rc("resl", acs_pkg::OFF_RESL, 16'h0055);
    rc("prev", acs_pkg::OFF_PREV, 16'h02a5);
    rc("acc", acs_pkg::OFF_ACC, 16'h03fa);
    rc("err", acs_pkg::OFF_ERR, 16'h01ab);
    rc("stpe", acs_pkg::OFF_STPE, 16'hfeb0);
    rc("stat", acs_pkg::OFF_STAT, 16'h0007);
    irq_is(1'b1);
    wr(acs_pkg::OFF_STAT, 16'h0007);
    wr(acs_pkg::OFF_MASK, 16'h0000);
  endtask

  task t_double;
    conv(10'h010, 16'h001b);
    rc("err", acs_pkg::OFF_ERR, 16'h01ab);
    rc("stat", acs_pkg::OFF_STAT, 16'h0005);
    conv(10'h020, 16'h001b);
    rc("err", acs_pkg::OFF_ERR, 16'h02e0);
    wr(acs_pkg::OFF_STAT, 16'h0007);
  endtask

  task t_trig;
    level = 10'h0aa;
    // stage error selected as threshold source
    wr(acs_pkg::OFF_CTRL, 16'h0021);
    @(posedge clock);
    extTrig <= 1'b1;
    @(posedge clock);
    extTrig <= 1'b0;
    repeat (16) @(posedge clock);
    rc("resl", acs_pkg::OFF_RESL, 16'h00aa);
    rc("stpe", acs_pkg::OFF_STPE, 16'h009a);
    rc("stat", acs_pkg::OFF_STAT, 16'h0005);
    wr(acs_pkg::OFF_STAT, 16'h0007);
  endtask

  task t_cont;
    conv(10'h0ff, 16'h0007);
    rc("ctrl", acs_pkg::OFF_CTRL, 16'h0007);
    wr(acs_pkg::OFF_STAT, 16'h0007);
    repeat (16) @(posedge clock);
    rc("stat", acs_pkg::OFF_STAT, 16'h0007);
    wr(acs_pkg::OFF_CTRL, 16'h0000);
    repeat (16) @(posedge clock);
    wr(acs_pkg::OFF_STAT, 16'h0007);
  endtask

  // abort lands while the top bits are being resolved
  task t_abort;
    level = 10'h3c0;
    wr(acs_pkg::OFF_CTRL, 16'h0001);
    wr(acs_pkg::OFF_CTRL, 16'h0003);
    repeat (2) @(posedge clock);
    #1;
    `CHK("sampling", 1'b1, sampling)
    wr(acs_pkg::OFF_CTRL, 16'h0001);
    repeat (16) @(posedge clock);
    rc("resh", acs_pkg::OFF_RESH, 16'h0003);
    rc("resl", acs_pkg::OFF_RESL, 16'h00ff);
    `CHK("dac", 10'h3ff, dacCode)
    rc("err", acs_pkg::OFF_ERR, 16'hff01);
  endtask

  initial begin
    sys_rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    extTrig = 1'b0;
    level = 10'h000;
    t_reset;
    t_disabled;
    t_basic;
    t_thresh;
    t_double;
    t_trig;
    t_cont;
    t_abort;
    t_reset;
    print_verdict;
  end
endmodule
